// [rtl/fspc_defs.vh]
`ifndef FSPC_DEFS_VH
`define FSPC_DEFS_VH
// ==========================================================
// Control/status bit positions.
`define FSPC_BIT_EN 0
`define FSPC_BIT_ERASE 1
`define FSPC_BIT_WRITE 2
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_REEN 4
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_IE 7
// ==========================================================
// Accepted command codes in the low five control bits.
`define FSPC_CMD_LOAD 5'h01
`define FSPC_CMD_ERASE 5'h03
`define FSPC_CMD_WRITE 5'h05
`define FSPC_CMD_LOCK 5'h09
`define FSPC_CMD_REEN 5'h11
// ==========================================================
// Register offsets on the plain port.
`define FSPC_OFF_CSR 2'h0
`define FSPC_OFF_EXT 2'h1
`define FSPC_RESET_CSR 8'h00
// ==========================================================
// Windows and timing.
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
`define FSPC_CLK_HZ 10000000
`define FSPC_PROG_MIN_US 3700
`define FSPC_PROG_MAX_US 4500
`define FSPC_PROG_CYC ((`FSPC_PROG_MIN_US * (`FSPC_CLK_HZ / 1000000)))
`endif

// [rtl/fspc_ctrl.v]
// The register offsets and strobed register access are this design's own decisions.
`include "fspc_defs.vh"
`default_nettype none
module fspc_ctrl #(
  parameter WORD_BITS = 7,
  parameter PAGE_BITS = 9,
  parameter READABLE_DURING_WRITE_REGION_PAGE = 9'h1e0,
  parameter PROG_CYCLES = `FSPC_PROG_CYC
) (
  // Clock, reset and enable.
  input wire clk,
  input wire arst_n,
  input wire clk_en,
  // Register port.
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Core instruction side.
  input wire store_req,
  input wire load_req,
  input wire [15:0] pointer,
  input wire [15:0] r1r0,
  input wire global_ie,
  input wire eeprom_wr,
  input wire [7:0] lock_bits,
  input wire [7:0] fuse_bits,
  output reg [7:0] load_data,
  output reg load_valid,
  output reg core_halt,
  output reg rww_blocked,
  output reg ready_irq,
  // Flash array side.
  output reg [15:0] buf_word,
  output reg [WORD_BITS-1:0] buf_index,
  output reg buf_we,
  output reg buf_clear,
  output reg [PAGE_BITS-1:0] page_addr,
  output reg page_erase,
  output reg page_write,
  output reg lock_write
);
  // ==========================================================
  // Overview of the sequencing.
  // A write to the control/status register arms one command.
  // The arming window then counts enabled core clock cycles.
  // A store request inside the window carries out the armed command.
  // If no store arrives, the command bits clear themselves.
  // Erase, write and lock programming run a fixed cycle timer.
  // The enable bit stays set until that timer has run out.
  // While the timer runs, every new command and every store is refused.
  // The ready request is derived from the enable bit each cycle.
  // Every output is a flip-flop, so all answers come one cycle late.
  // The core sees this one-cycle latency on load data as well.
  // ==========================================================
  // Hazards worth knowing.
  // A store in the last window cycle must still win over the expiry.
  // Otherwise an erase would start with its enable bit already gone.
  // A store in the same cycle as a control write with a valid command code is ignored.
  // That keeps the old and new command from mixing in one cycle.
  // The page address is latched when an operation starts.
  // Software may then reuse the pointer for other work.
  // The timer is a plain down counter on the core clock.
  // A real part would time this from its own oscillator instead.
  // Low clock enable freezes the windows and the timer alike.
  // ==========================================================
  // State.
  reg [4:0] cmd_q; // Armed command bits.
  reg ie_q; // Ready interrupt enable.
  reg busy_q; // Section-busy flag.
  reg [7:0] ext_q; // Page-select extension.
  reg [2:0] win_q; // Arming window countdown.
  reg [2:0] lwin_q; // Load-program window countdown.
  reg prog_q; // Operation running.
  reg [31:0] tmr_q; // Programming time left, in cycles.
  reg loading_q; // Buffer partly loaded.
  wire [23:0] full_addr = {ext_q, pointer};
  wire [PAGE_BITS-1:0] sel_page = full_addr[WORD_BITS+1 +: PAGE_BITS];
  wire wr_csr = reg_wr && reg_addr == `FSPC_OFF_CSR;
  wire csr_code_ok = reg_wdata[4:0] == `FSPC_CMD_LOAD || reg_wdata[4:0] == `FSPC_CMD_ERASE ||
    reg_wdata[4:0] == `FSPC_CMD_WRITE || reg_wdata[4:0] == `FSPC_CMD_LOCK ||
    reg_wdata[4:0] == `FSPC_CMD_REEN;
  wire armed = win_q != 3'h0 && !prog_q;
  wire do_store = armed && store_req;
  wire reen_wr = wr_csr && reg_wdata[`FSPC_BIT_REEN];
  // ==========================================================
  // Main sequencing process; writes take the cycle, windows start next cycle.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= 5'h00;
      ie_q <= 1'b0;
      busy_q <= 1'b0;
      ext_q <= 8'h00;
      win_q <= 3'h0;
      lwin_q <= 3'h0;
      prog_q <= 1'b0;
      tmr_q <= 32'h0;
      loading_q <= 1'b0;
      reg_rdata <= 8'h00;
      load_data <= 8'h00;
      load_valid <= 1'b0;
      core_halt <= 1'b0;
      rww_blocked <= 1'b0;
      ready_irq <= 1'b0;
      buf_word <= 16'h0000;
      buf_index <= {WORD_BITS{1'b0}};
      buf_we <= 1'b0;
      buf_clear <= 1'b1;
      page_addr <= {PAGE_BITS{1'b0}};
      page_erase <= 1'b0;
      page_write <= 1'b0;
      lock_write <= 1'b0;
    end else if (clk_en) begin
      buf_we <= 1'b0;
      buf_clear <= 1'b0;
      load_valid <= 1'b0;
      page_erase <= 1'b0;
      page_write <= 1'b0;
      lock_write <= 1'b0;
      // Read port answers one cycle after the strobe.
      if (reg_rd) begin
        case (reg_addr)
          `FSPC_OFF_CSR: reg_rdata <= {ie_q, busy_q, 1'b0, cmd_q};
          `FSPC_OFF_EXT: reg_rdata <= ext_q;
          default: reg_rdata <= 8'h00;
        endcase
      end
      if (reg_wr && reg_addr == `FSPC_OFF_EXT) begin
        ext_q <= reg_wdata;
      end
      if (wr_csr) begin
        ie_q <= reg_wdata[`FSPC_BIT_IE];
      end
      // Window countdowns expire the armed command.
      // A store taken in the last window cycle must keep its command.
      if (win_q != 3'h0) begin
        win_q <= win_q - 3'h1;
        if (win_q == 3'h1 && !prog_q && !do_store) begin
          cmd_q <= 5'h00;
        end
      end
      if (lwin_q != 3'h0) begin
        lwin_q <= lwin_q - 3'h1;
      end
      // Accept a new command only when idle; a running operation refuses it, the busy bit does not.
      if (wr_csr && csr_code_ok && !prog_q) begin
        cmd_q <= reg_wdata[4:0];
        win_q <= `FSPC_STORE_WIN;
        lwin_q <= (reg_wdata[4:0] == `FSPC_CMD_LOCK) ? `FSPC_LOAD_WIN : 3'h0;
      end
      // Re-enable write discards a partial load.
      if (reen_wr && !prog_q) begin
        buf_clear <= 1'b1;
        loading_q <= 1'b0;
      end
      if (eeprom_wr && loading_q) begin
        buf_clear <= 1'b1;
        loading_q <= 1'b0;
      end
      // Lock or fuse read by load-program.
      if (load_req && lwin_q != 3'h0 && cmd_q == `FSPC_CMD_LOCK && !prog_q) begin
        load_data <= pointer[0] ? lock_bits : fuse_bits;
        load_valid <= 1'b1;
        cmd_q <= 5'h00;
        win_q <= 3'h0;
        lwin_q <= 3'h0;
      end
      // Store-program executes the armed command.
      if (do_store && !(wr_csr && csr_code_ok)) begin
        win_q <= 3'h0;
        lwin_q <= 3'h0;
        case (cmd_q)
          `FSPC_CMD_LOAD: begin
            buf_word <= r1r0;
            buf_index <= full_addr[WORD_BITS:1];
            buf_we <= 1'b1;
            loading_q <= 1'b1;
            busy_q <= 1'b0;
            rww_blocked <= 1'b0;
            cmd_q <= 5'h00;
          end
          `FSPC_CMD_ERASE, `FSPC_CMD_WRITE: begin
            page_addr <= sel_page;
            page_erase <= cmd_q == `FSPC_CMD_ERASE;
            page_write <= cmd_q == `FSPC_CMD_WRITE;
            prog_q <= 1'b1;
            tmr_q <= PROG_CYCLES;
            if (sel_page >= READABLE_DURING_WRITE_REGION_PAGE) begin
              core_halt <= 1'b1;
            end else begin
              busy_q <= 1'b1;
              rww_blocked <= 1'b1;
            end
          end
          `FSPC_CMD_LOCK: begin
            lock_write <= 1'b1;
            prog_q <= 1'b1;
            tmr_q <= PROG_CYCLES;
          end
          `FSPC_CMD_REEN: begin
            busy_q <= 1'b0;
            rww_blocked <= 1'b0;
            cmd_q <= 5'h00;
          end
          default: cmd_q <= 5'h00;
        endcase
      end
      // Programming timer; completion clears command bits.
      // The halt is dropped in the same cycle that the enable bit clears.
      if (prog_q) begin
        if (tmr_q <= 32'h1) begin
          prog_q <= 1'b0;
          core_halt <= 1'b0;
          cmd_q <= 5'h00;
          if (cmd_q == `FSPC_CMD_WRITE) begin
            buf_clear <= 1'b1;
            loading_q <= 1'b0;
          end
        end else begin
          tmr_q <= tmr_q - 32'h1;
        end
      end
      // Ready interrupt held while enable bit reads clear.
      ready_irq <= ie_q && global_ie && !cmd_q[`FSPC_BIT_EN];
    end
  end
endmodule
`default_nettype wire

// [dv/fspc_ctrl_props.sv]
`default_nettype none
module fspc_ctrl_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Core side.
  input wire logic store_req,
  input wire logic load_req,
  input wire logic global_ie,
  input wire logic load_valid,
  input wire logic core_halt,
  input wire logic rww_blocked,
  input wire logic ready_irq,
  // Array side.
  input wire logic buf_we,
  input wire logic page_erase,
  input wire logic page_write,
  input wire logic lock_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========
  // Each answer pulse must trace back to a request taken one cycle before.
  a_load_cause: assert property (load_valid |-> $past(load_req))
    else $error("load answer without load request");
  a_fill_cause: assert property (buf_we |-> $past(store_req))
    else $error("buffer write without store");
  a_erase_cause: assert property (page_erase |-> $past(store_req))
    else $error("erase start without store");
  a_write_cause: assert property (page_write |-> $past(store_req))
    else $error("page write start without store");
  a_lock_cause: assert property (lock_write |-> $past(store_req))
    else $error("lock write without store");
  // One store can only ever mean one command.
  a_one_start: assert property ($onehot0({buf_we, page_erase, page_write, lock_write}))
    else $error("two commands started at once");
  a_halt_start: assert property ($rose(core_halt) |-> (page_erase || page_write))
    else $error("core halted with no operation");
  a_busy_start: assert property ($rose(rww_blocked) |-> (page_erase || page_write))
    else $error("busy set with no operation");
  a_irq_gate: assert property (ready_irq |-> $past(global_ie))
    else $error("ready request without global enable");
endmodule
bind fspc_ctrl fspc_ctrl_props u_props (.*);
`default_nettype wire

// [dv/fspc_core_model.sv]
`default_nettype none
module fspc_core_model (
  // Clock and stall.
  input wire logic clk,
  input wire logic core_halt,
  // Instruction side.
  output var logic store_req = 1'b0,
  output var logic load_req = 1'b0,
  output var logic [15:0] pointer = 16'h0000,
  output var logic [15:0] r1r0 = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Issues one store or load d cycles after the arming write.
  // A stalled core fetches nothing, so it waits out a halt first.
  task automatic op(input int d, input bit ld, input logic [15:0] p, input logic [15:0] w);
    repeat (d - 1) @(posedge clk);
    while (core_halt === 1'b1) @(posedge clk);
    pointer <= p;
    r1r0 <= w;
    store_req <= !ld;
    load_req <= ld;
    @(posedge clk);
    store_req <= 1'b0;
    load_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/fspc_ctrl_tb.sv]
`default_nettype none
module fspc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0, global_ie = 0, eeprom_wr = 0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, lock_bits = 8'h3c, fuse_bits = 8'ha5, reg_rdata, load_data;
  logic store_req, load_req, load_valid, core_halt, rww_blocked, ready_irq, buf_we, buf_clear;
  logic page_erase, page_write, lock_write;
  logic [15:0] pointer, r1r0, buf_word;
  logic [6:0] buf_index;
  logic [8:0] page_addr;
  int err_total = 0, n_checks = 0;
  // Short programming time keeps the run brief.
  fspc_ctrl #(.PROG_CYCLES(20)) u_fspc_ctrl (.*);
  fspc_core_model u_fspc_core_model (.*);
  initial forever #50 clk = ~clk;
  // ==========
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // Fill, late store, bad code and unmapped read.
  task automatic t_fill;
    wr(2'h0, 8'h01);
    u_fspc_core_model.op(1, 0, 16'h0006, 16'h1234);
    #1 chk(buf_we, 1'b1);
    chk(buf_word, 16'h1234);
    chk(buf_index, 7'h03);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h01);
    u_fspc_core_model.op(5, 0, 16'h0008, 16'h5678);
    #1 chk(buf_we, 1'b0);
    wr(2'h0, 8'h07);
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
    $display("t_fill done");
  endtask
  // Erase to the blocked region, refused re-enable, then re-enable.
  task automatic t_erase;
    wr(2'h0, 8'h03);
    u_fspc_core_model.op(4, 0, 16'h0300, 16'hffff);
    #1 chk(page_erase, 1'b1);
    chk({rww_blocked, core_halt}, 2'h2);
    rd(2'h0, 8'h43);
    wr(2'h0, 8'h11);
    u_fspc_core_model.op(1, 0, 16'hff00, 16'h0000);
    rd(2'h0, 8'h43);
    chk(page_addr, 9'h003);
    repeat (25) @(posedge clk);
    rd(2'h0, 8'h40);
    wr(2'h0, 8'h11);
    u_fspc_core_model.op(1, 0, 16'h0000, 16'h0000);
    rd(2'h0, 8'h00);
    $display("t_erase done");
  endtask
  // Page write to the core-halting region through the extension register.
  task automatic t_write;
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h05);
    u_fspc_core_model.op(2, 0, 16'he000, 16'h0000);
    #1 chk(page_write, 1'b1);
    chk(page_addr, 9'h1e0);
    chk({rww_blocked, core_halt}, 2'h1);
    repeat (25) @(posedge clk);
    #1 chk(core_halt, 1'b0);
    wr(2'h1, 8'h00);
    rd(2'h0, 8'h00);
    $display("t_write done");
  endtask
  // Lock and fuse reads, then lock programming.
  task automatic t_lock;
    wr(2'h0, 8'h09);
    u_fspc_core_model.op(3, 1, 16'h0001, 16'h0000);
    #1 chk({load_valid, load_data}, 9'h13c);
    wr(2'h0, 8'h09);
    u_fspc_core_model.op(1, 1, 16'h0000, 16'h0000);
    #1 chk({load_valid, load_data}, 9'h1a5);
    wr(2'h0, 8'h09);
    u_fspc_core_model.op(4, 0, 16'h0000, 16'h00f3);
    #1 chk(lock_write, 1'b1);
    repeat (25) @(posedge clk);
    rd(2'h0, 8'h00);
    $display("t_lock done");
  endtask
  // Buffer discards, busy clear by load, and a frozen window.
  task automatic t_clear;
    wr(2'h0, 8'h01);
    u_fspc_core_model.op(1, 0, 16'h0002, 16'habcd);
    eeprom_wr <= 1'b1;
    @(posedge clk);
    eeprom_wr <= 1'b0;
    #1 chk(buf_clear, 1'b1);
    wr(2'h0, 8'h01);
    u_fspc_core_model.op(1, 0, 16'h0004, 16'h0000);
    wr(2'h0, 8'h11);
    #1 chk(buf_clear, 1'b1);
    wr(2'h0, 8'h03);
    u_fspc_core_model.op(1, 0, 16'h0400, 16'h0000);
    repeat (25) @(posedge clk);
    rd(2'h0, 8'h40);
    wr(2'h0, 8'h01);
    u_fspc_core_model.op(1, 0, 16'h0006, 16'h0000);
    rd(2'h0, 8'h00);
    wr(2'h0, 8'h01);
    clk_en <= 1'b0;
    repeat (6) @(posedge clk);
    clk_en <= 1'b1;
    u_fspc_core_model.op(1, 0, 16'h0008, 16'h0000);
    #1 chk(buf_we, 1'b1);
    $display("t_clear done");
  endtask
  // Ready request follows the enable bit.
  task automatic t_irq;
    global_ie <= 1'b1;
    wr(2'h0, 8'h80);
    repeat (2) @(posedge clk);
    #1 chk(ready_irq, 1'b1);
    wr(2'h0, 8'h81);
    repeat (2) @(posedge clk);
    #1 chk(ready_irq, 1'b0);
    repeat (8) @(posedge clk);
    #1 chk(ready_irq, 1'b1);
    global_ie <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(ready_irq, 1'b0);
    $display("t_irq done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 chk(buf_clear, 1'b1);
    arst_n <= 1'b1;
    t_fill();
    t_erase();
    t_write();
    t_lock();
    t_clear();
    t_irq();
    test_done();
  end
  // Tests need well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
